// [design/phsc_pkg.sv]
// Behaviour
// - control bit 7 set drives eeprom status on status pin, else comparator or selector path.
// - bit 6 enables the crystal maintaining amplifier; cleared disables it.
// - bit 5 enables the reference doubler; cleared disables it.
// - bit 4 set freezes status readback register; cleared keeps it refreshing.
// - bit 3 set in automatic holdover uses lock detect comparator result.
// - bit 3 cleared ignores lock detect pin, holdover sees it true.
// - bit 3 set outside automatic holdover shows comparator result on monitor pin, and on status pin when bit 7 is clear.
// - bit 1 set hands holdover to align pin, internal control disabled.
// - bit 0 enables internal holdover; cleared keeps holdover disabled unless bit 1 is set.
// - readback bit 5 reports holdover currently active, not merely enabled.
package phsc_pkg;
    localparam logic [7:0] PHSC_CTRL_OFS = 8'h1d;
    localparam logic [7:0] PHSC_RDBK_OFS = 8'h1f;
    localparam logic [7:0] PHSC_IRQ_STAT_OFS = 8'h20;
    localparam logic [7:0] PHSC_IRQ_MASK_OFS = 8'h21;
    localparam int PHSC_ADDR_W = 8;
    localparam int PHSC_BIT_EEPROM = 7;
    localparam int PHSC_BIT_XTAL = 6;
    localparam int PHSC_BIT_DBL = 5;
    localparam int PHSC_BIT_FRZ = 4;
    localparam int PHSC_BIT_LDCMP = 3;
    localparam int PHSC_BIT_EXTHO = 1;
    localparam int PHSC_BIT_HOEN = 0;
    localparam int PHSC_RB_HOACT = 5;
    localparam logic [7:0] PHSC_CTRL_RST = 8'h80;
    localparam logic [7:0] PHSC_CTRL_WMASK = 8'hfb;
    localparam logic [7:0] PHSC_RDBK_RST = 8'h00;
    localparam logic [1:0] PHSC_IRQ_RST = 2'h0;
    typedef struct packed {
        logic eeprom_sel;
        logic crystal_amp;
        logic doubler;
        logic freeze;
        logic ld_cmp;
        logic ext_ho;
        logic ho_en;
    } phsc_ctrl_t;
endpackage : phsc_pkg

// [design/phsc_sync.sv]
// three-stage input synchroniser, change accepted when stages 2 and 3 agree
module phsc_sync
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // sync reset
    input wire logic d_i, // async input
    output logic q_o // filtered level
);
    logic s1_q, s2_q, s3_q, q_q;
    logic q_d;
    // next filtered level only on agreement
    always_comb
    begin
        q_d = (s2_q == s3_q) ? s3_q : q_q;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_q <= 1'b0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end
    assign q_o = q_q;
endmodule // phsc_sync

// [design/phsc_wb.sv]
// classic wishbone slave front end, ack one cycle after request seen
module phsc_wb
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // sync reset
    input wire logic cyc_i, // bus cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write enable
    input wire logic sel_i, // byte lane 0 select
    output logic ack_o, // acknowledge
    output logic wr_o, // write strobe to bank
    output logic rd_o // read strobe to bank
);
    logic ack_q, ack_d;
    // ack dropped after one cycle so a held request is not taken twice
    always_comb
    begin
        ack_d = cyc_i & stb_i & ~ack_q;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= ack_d;
    end
    assign ack_o = ack_q;
    // write lands at the edge where the master samples ack high
    assign wr_o = ack_q & cyc_i & stb_i & we_i & sel_i;
    assign rd_o = ack_d & ~we_i;
endmodule // phsc_wb

// [design/phsc_top.sv]
// Our own choice: the Wishbone register port.
module phsc_top
(
    input wire logic clk_i, // 250 mhz clock
    input wire logic rst_i, // sync reset, high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [phsc_pkg::PHSC_ADDR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic eeprom_status_i, // eeprom status signal
    input wire logic status_sel_i, // status from selector field path
    input wire logic reference_monitor_pin_sel_i, // monitor from its selector path
    input wire logic ld_cmp_raw_i, // lock detect comparator, async
    input wire logic output_align_i, // align pin hold request, async
    input wire logic auto_ho_cond_i, // automatic holdover trigger
    input wire logic [7:0] pll_status_i, // live pll status bits
    output logic status_pin_o, // status output pin
    output logic reference_monitor_pin_o, // monitor output pin
    output phsc_pkg::phsc_ctrl_t ctrl_o, // control fields
    output logic holdover_o, // holdover active
    output logic irq_o // level interrupt
);
    import phsc_pkg::*;

    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rdbk_q, rdbk_d;
    logic ho_q, ho_d;
    logic [1:0] ist_q, ist_d;
    logic [1:0] imsk_q, imsk_d;
    logic [31:0] dat_q, dat_d;
    logic wr, rd, ack, ld_s, align_s, ld_eff, auto_mode, ho_prev_q;
    logic [1:0] ev;

    phsc_wb u_wb
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .sel_i(wb_sel_i[0]),
        .ack_o(ack),
        .wr_o(wr),
        .rd_o(rd)
    );
    phsc_sync u_ld
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ld_cmp_raw_i),
        .q_o(ld_s)
    );
    phsc_sync u_al
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(output_align_i),
        .q_o(align_s)
    );

    // lock detect as seen by the holdover controller
    assign ld_eff = ctrl_q[PHSC_BIT_LDCMP] ? ld_s : 1'b1;
    assign auto_mode = ctrl_q[PHSC_BIT_HOEN] & ~ctrl_q[PHSC_BIT_EXTHO];

    // holdover decision; with bit 3 set, automatic holdover needs lock detect true
    always_comb
    begin
        if (ctrl_q[PHSC_BIT_EXTHO])
            ho_d = align_s;
        else if (ctrl_q[PHSC_BIT_HOEN])
            ho_d = auto_ho_cond_i & ld_eff;
        else
            ho_d = 1'b0;
    end

    // events: holdover entry and exit
    assign ev = {ho_prev_q & ~ho_q, ~ho_prev_q & ho_q};

    // register writes, sticky status where set beats clear
    always_comb
    begin
        ctrl_d = ctrl_q;
        imsk_d = imsk_q;
        ist_d = ist_q;
        if (wr && wb_adr_i == PHSC_CTRL_OFS)
            ctrl_d = wb_dat_i[7:0] & PHSC_CTRL_WMASK;
        if (wr && wb_adr_i == PHSC_IRQ_MASK_OFS)
            imsk_d = wb_dat_i[1:0];
        if (wr && wb_adr_i == PHSC_IRQ_STAT_OFS)
            ist_d = ist_q & ~wb_dat_i[1:0];
        ist_d = ist_d | ev;
    end

    // readback refreshed unless frozen; holdover flag in bit 5
    always_comb
    begin
        rdbk_d = rdbk_q;
        if (!ctrl_q[PHSC_BIT_FRZ])
        begin
            rdbk_d = pll_status_i;
            rdbk_d[PHSC_RB_HOACT] = ho_q;
        end
    end

    // read mux, unmapped reads zero
    always_comb
    begin
        dat_d = dat_q;
        if (rd)
        begin
            case (wb_adr_i)
                PHSC_CTRL_OFS: dat_d = {24'h0, ctrl_q};
                PHSC_RDBK_OFS: dat_d = {24'h0, rdbk_q};
                PHSC_IRQ_STAT_OFS: dat_d = {30'h0, ist_q};
                PHSC_IRQ_MASK_OFS: dat_d = {30'h0, imsk_q};
                default: dat_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= PHSC_CTRL_RST;
            rdbk_q <= PHSC_RDBK_RST;
            ho_q <= 1'b0;
            ho_prev_q <= 1'b0;
            ist_q <= PHSC_IRQ_RST;
            imsk_q <= PHSC_IRQ_RST;
            dat_q <= 32'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rdbk_q <= rdbk_d;
            ho_q <= ho_d;
            ho_prev_q <= ho_q;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            dat_q <= dat_d;
        end
    end

    // pin muxes; eeprom status overrides selector path
    always_comb
    begin
        if (ctrl_q[PHSC_BIT_EEPROM])
            status_pin_o = eeprom_status_i;
        else if (ctrl_q[PHSC_BIT_LDCMP] && !auto_mode)
            status_pin_o = ld_s;
        else
            status_pin_o = status_sel_i;
        if (ctrl_q[PHSC_BIT_LDCMP] && !auto_mode)
            reference_monitor_pin_o = ld_s;
        else
            reference_monitor_pin_o = reference_monitor_pin_sel_i;
    end

    assign ctrl_o = {ctrl_q[7:3], ctrl_q[1:0]};
    assign holdover_o = ho_q;
    assign irq_o = |(ist_q & imsk_q);
    assign wb_ack_o = ack;
    assign wb_dat_o = dat_q;

    // checks
    a_eeprom_override: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q[7] |-> status_pin_o == eeprom_status_i)
        else $error("status pin not eeprom");
    a_xtal_field: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_o.crystal_amp == ctrl_q[6])
        else $error("crystal amp mismatch");
    a_dbl_field: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_o.doubler == ctrl_q[5])
        else $error("doubler mismatch");
    a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q[4] |=> $stable(rdbk_q))
        else $error("readback moved while frozen");
    a_ld_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (auto_mode && ctrl_q[3] && !ld_s) |=> !ho_q)
        else $error("holdover without lock");
    a_ld_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        (auto_mode && !ctrl_q[3]) |=> ho_q == $past(auto_ho_cond_i))
        else $error("lock detect not ignored");
    a_ld_monitor: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[3] && !auto_mode) |-> reference_monitor_pin_o == ld_s)
        else $error("monitor pin wrong");
    a_ext_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q[1] |=> ho_q == $past(align_s))
        else $error("external holdover wrong");
    a_ho_disable: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[1:0] == 2'h0) |=> !ho_q)
        else $error("holdover while disabled");
    a_rb_hoact: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[4] |=> rdbk_q[5] == $past(ho_q))
        else $error("readback holdover bit wrong");
    a_bit2_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[2])
        else $error("unused bit set");
    a_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (ev != 2'h0) |=> (ist_q & $past(ev)) == $past(ev))
        else $error("status event lost");
    c_ext_hold: cover property (@(posedge clk_i) ctrl_q[1] && ho_q);
    c_auto_hold: cover property (@(posedge clk_i) auto_mode && ho_q);
    c_frozen: cover property (@(posedge clk_i) ctrl_q[4] && wr);
    c_irq: cover property (@(posedge clk_i) irq_o);
endmodule // phsc_top

// [sim/phsc_top_bench.sv]
module phsc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import phsc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00, pll = 8'h00, r, v, a_pll;
    logic [31:0] wdat = '0, rdat;
    logic eep = 1'b1, ssel = 1'b0, msel = 1'b0, ld = 1'b0;
    logic align = 1'b0, cond = 1'b0, spin, mpin, hold, irq;
    phsc_ctrl_t ctrl;
    int err_count = 0;
    int total_checks = 0;

    phsc_top i_phsc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .eeprom_status_i(eep), .status_sel_i(ssel), .reference_monitor_pin_sel_i(msel),
        .ld_cmp_raw_i(ld), .output_align_i(align), .auto_ho_cond_i(cond),
        .pll_status_i(pll), .status_pin_o(spin),
        .reference_monitor_pin_o(mpin), .ctrl_o(ctrl), .holdover_o(hold),
        .irq_o(irq));

    // free-running 250 mhz clock
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string name);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        r = rdat[7:0];
        chk({31'h0, ack}, 32'h1, "wb_ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, string s);
        wb(1'b0, a, 8'h00);
        chk({24'h0, r}, {24'h0, e}, s);
    endtask

    // wait past the input synchroniser, sample off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        #8000;
        err_count++;
        close_out();
    end

    initial
    begin
        void'($urandom(54766));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(PHSC_CTRL_OFS, 8'h80, "ctrl reset");
        rd(PHSC_RDBK_OFS, 8'h00, "rdbk reset");
        rd(PHSC_IRQ_MASK_OFS, 8'h00, "mask reset");
        rd(8'h33, 8'h00, "unmapped");
        chk(spin, eep, "status eeprom");
        $display("test reset done");
        // random ctrl without holdover bits, bit 2 forced to one
        repeat (6)
        begin
            v = ($urandom() | 8'h04) & 8'hfc;
            @(posedge clk_i);
            {eep, ssel, msel, ld} <= 4'($urandom());
            wb(1'b1, PHSC_CTRL_OFS, v);
            settle(8);
            rd(PHSC_CTRL_OFS, v & 8'hfb, "ctrl rw");
            chk(ctrl, {v[7:3], v[1:0]}, "ctrl_o");
            chk(spin, v[7] ? eep : (v[3] ? ld : ssel), "status");
            chk(mpin, v[3] ? ld : msel, "monitor");
        end
        $display("test ctrl fields done");
        a_pll = 8'($urandom());
        @(posedge clk_i);
        pll <= a_pll;
        cond <= 1'b1;
        wb(1'b1, PHSC_CTRL_OFS, 8'h03);
        settle(8);
        chk(hold, 1'b0, "ext hold idle");
        @(posedge clk_i);
        align <= 1'b1;
        settle(8);
        chk(hold, 1'b1, "ext hold");
        rd(PHSC_RDBK_OFS, a_pll | 8'h20, "rdbk hold");
        rd(PHSC_IRQ_STAT_OFS, 8'h01, "irq enter");
        wb(1'b1, PHSC_IRQ_MASK_OFS, 8'h01);
        settle(1);
        chk(irq, 1'b1, "irq on");
        wb(1'b1, PHSC_IRQ_STAT_OFS, 8'h01);
        settle(1);
        chk(irq, 1'b0, "irq cleared");
        @(posedge clk_i);
        align <= 1'b0;
        settle(8);
        chk(hold, 1'b0, "ext release");
        rd(PHSC_IRQ_STAT_OFS, 8'h02, "irq leave");
        chk(irq, 1'b0, "irq masked");
        wb(1'b1, PHSC_IRQ_MASK_OFS, 8'h03);
        settle(1);
        chk(irq, 1'b1, "irq unmasked");
        wb(1'b1, PHSC_IRQ_STAT_OFS, 8'h03);
        $display("test external holdover done");
        // automatic mode: lock detect ignored, then compared
        {ld, ssel, eep} <= 3'b000;
        wb(1'b1, PHSC_CTRL_OFS, 8'h01);
        settle(8);
        chk(hold, 1'b1, "auto hold ld off");
        ld <= 1'b1;
        wb(1'b1, PHSC_CTRL_OFS, 8'h09);
        settle(8);
        chk(hold, 1'b1, "auto hold ld on");
        chk(spin, 1'b0, "status auto");
        chk(mpin, msel, "monitor auto");
        wb(1'b1, PHSC_CTRL_OFS, 8'h00);
        settle(8);
        chk(hold, 1'b0, "hold disabled");
        $display("test automatic holdover done");
        // freeze keeps the last readback value
        wb(1'b1, PHSC_CTRL_OFS, 8'h10);
        settle(2);
        @(posedge clk_i);
        pll <= ~a_pll;
        settle(4);
        rd(PHSC_RDBK_OFS, a_pll & 8'hdf, "rdbk frozen");
        wb(1'b1, PHSC_CTRL_OFS, 8'h00);
        settle(4);
        rd(PHSC_RDBK_OFS, ~a_pll & 8'hdf, "rdbk live");
        $display("test freeze done");
        close_out();
    end
endmodule // phsc_top_bench
